// File: ilr_checker.sv
// Purpose: property checks on the level assignment registers
// Assumes: zero-wait apb, level fields registered at the access edge
// Notes:   stored fields show one cycle after the write edge
`timescale 1ns/100ps
`default_nettype none
module ilr_checker
  import ilr_pkg::*;
(
  input  wire logic              clk,         // system clock
  input  wire logic              rst,         // sync reset
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access
  input  wire logic              pwrite,      // apb write
  input  wire logic [ADDR_W-1:0] paddr,       // apb address
  input  wire logic [DATA_W-1:0] pwdata,      // apb write data
  input  wire logic [DATA_W-1:0] prdata,      // apb read data
  input  wire logic              timer2Req,   // timer 2 request
  input  wire ilr_levels_s       levels,      // level fields
  input  wire logic [NSRC-1:0]   srcPending,  // pending sources
  input  wire ilr_top_s          top          // winner
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel && penable;
  AST_T2: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG1 |=>
    levels.timer2Level == $past(pwdata[26:24])) else $error("timer 2 level not stored");
  AST_T1: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG1 |=>
    levels.timer1Level == $past(pwdata[18:16])) else $error("timer 1 level not stored");
  AST_E1: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG1 |=>
    levels.extIn1Level == $past(pwdata[10:8])) else $error("ext 1 level not stored");
  AST_E0: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG1 |=>
    levels.extIn0Level == $past(pwdata[2:0])) else $error("ext 0 level not stored");
  AST_NAND: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG2 |=>
    levels.nandCtrlLevel == $past(pwdata[26:24])) else $error("nand level not stored");
  AST_E3: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG2 |=>
    levels.extIn3SharedLevel == $past(pwdata[10:8])) else $error("ext 3 level not stored");
  AST_E2: assert property (acc && pwrite && paddr == ADDR_LEVEL_CFG2 |=>
    levels.extIn2Level == $past(pwdata[2:0])) else $error("ext 2 level not stored");
  AST_DIS: assert property (srcPending[6] |-> $past(timer2Req) &&
    $past(levels.timer2Level) != 3'h0) else $error("disabled source pending");
  AST_TOP: assert property (top.valid |-> top.level != 3'h0)
    else $error("winner at level zero");
  AST_RSV2: assert property (acc && !pwrite && paddr == ADDR_LEVEL_CFG2 |->
    (prdata & ~MASK_LEVEL_CFG2) == 32'h0) else $error("reserved bits of config 2 set");
  AST_RSV1: assert property (acc && !pwrite && paddr == ADDR_LEVEL_CFG1 |->
    (prdata & ~MASK_LEVEL_CFG1) == 32'h0) else $error("reserved bits of config 1 set");
  AST_RST: assert property ($fell(rst) |-> levels == '0)
    else $error("levels not cleared by reset");
endmodule
`default_nettype wire

// File: ilr_level_regs.sv
// Purpose: level assignment registers 1 and 2 with level gating and resolution
// Assumes: APB slave, zero wait states; timer and nand requests on clk
// Notes:   external requests are pins and pass a synchroniser first
`timescale 1ns/100ps
`default_nettype none
module ilr_level_regs
  import ilr_pkg::*;
(
  input  wire logic              clk,            // system clock, 200 MHz
  input  wire logic              rst,            // sync reset, active high
  input  wire logic              psel,           // apb select
  input  wire logic              penable,        // apb access phase
  input  wire logic              pwrite,         // apb write
  input  wire logic [ADDR_W-1:0] paddr,          // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,         // apb write data
  output logic      [DATA_W-1:0] prdata,         // apb read data
  output logic                   pready,         // apb ready
  output logic                   pslverr,        // apb error, unmapped address
  input  wire logic              timer2Req,      // timer channel 2 request
  input  wire logic              timer1Req,      // timer channel 1 request
  input  wire logic              nandCtrlReq,    // nand flash controller request
  input  wire logic [3:0]        extInPin,       // external interrupt pins 0..3
  input  wire logic              ethCh1Req,      // ethernet channel 1 request
  output ilr_levels_s            levels,         // programmed levels
  output logic      [NSRC-1:0]   srcPending,     // requesting and enabled
  output ilr_top_s               top,            // winning source and level
  output logic                   irq             // event interrupt
);

  // ---------------- request conditioning ----------------
  logic [3:0]      extInSync;
  logic [NSRC-1:0] reqVec;

  ilr_sync #(
    .WIDTH (4)
  ) u_ext_sync (
    .clk    (clk),
    .rst    (rst),
    .async  (extInPin),
    .synced (extInSync)
  );

  // order: timer2, timer1, ext1, ext0, nand, ext3/eth1, ext2
  always_comb begin
    reqVec[6] = timer2Req;
    reqVec[5] = timer1Req;
    reqVec[4] = extInSync[1];
    reqVec[3] = extInSync[0];
    reqVec[2] = nandCtrlReq;
    // either requester raises the shared source; software cannot tell which one
    reqVec[1] = extInSync[3] | ethCh1Req;
    reqVec[0] = extInSync[2];
  end

  // ---------------- functions ----------------
  function automatic logic [LVL_W-1:0] field_of(
    input logic [DATA_W-1:0] word,
    input int                pos
  );
    field_of = word[pos +: LVL_W];
  endfunction

  function automatic logic level_enabled(input logic [LVL_W-1:0] lvl);
    level_enabled = (lvl != LEVEL_DISABLED);
  endfunction

  // levels flattened so a loop index picks a field; index 0 is timer 2
  function automatic logic [LVL_W-1:0] level_at(
    input ilr_levels_s lv,
    input int          idx
  );
    logic [NSRC*LVL_W-1:0] flat;
    flat     = lv;
    level_at = flat[(NSRC-1-idx)*LVL_W +: LVL_W];
  endfunction

  function automatic logic [SRC_W-1:0] source_at(input int idx);
    case (idx)
      0:       source_at = SRC_TIMER2;
      1:       source_at = SRC_TIMER1;
      2:       source_at = SRC_EXT_IN1;
      3:       source_at = SRC_EXT_IN0;
      4:       source_at = SRC_NAND;
      5:       source_at = SRC_EXT_IN3S;
      default: source_at = SRC_EXT_IN2;
    endcase
  endfunction

  // one select line per mapped register, shared by the write and error paths; the read mux decodes paddr itself
  localparam int SEL_CFG1   = 0;
  localparam int SEL_CFG2   = 1;
  localparam int SEL_STATUS = 2;
  localparam int SEL_ENABLE = 3;
  localparam int SEL_CLEAR  = 4;
  localparam int SEL_RESOLV = 5;
  localparam int SEL_N      = 6;

  function automatic logic [SEL_N-1:0] reg_select(input logic [ADDR_W-1:0] addr);
    reg_select = '0;
    case (addr)
      ADDR_LEVEL_CFG1: reg_select[SEL_CFG1]   = 1'b1;
      ADDR_LEVEL_CFG2: reg_select[SEL_CFG2]   = 1'b1;
      ADDR_EVT_STATUS: reg_select[SEL_STATUS] = 1'b1;
      ADDR_EVT_ENABLE: reg_select[SEL_ENABLE] = 1'b1;
      ADDR_EVT_CLEAR:  reg_select[SEL_CLEAR]  = 1'b1;
      ADDR_RESOLVED:   reg_select[SEL_RESOLV] = 1'b1;
      default:         reg_select = '0;
    endcase
  endfunction

  // ---------------- apb decode ----------------
  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic             addrHit;
  logic [SEL_N-1:0] regSel;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrAccess    = accessPhase & pwrite;
  assign regSel      = reg_select(paddr);
  assign addrHit     = |regSel;

  // zero wait states: read data is staged during setup
  assign pready  = accessPhase;
  // only unmapped addresses error; writes to read-only registers are dropped quietly
  assign pslverr = accessPhase & ~addrHit;

  // ---------------- level registers ----------------
  logic [DATA_W-1:0] cfg1;
  logic [DATA_W-1:0] cfg2;
  logic [DATA_W-1:0] next_cfg1;
  logic [DATA_W-1:0] next_cfg2;
  logic              cfg1Wr;
  logic              cfg2Wr;

  // reset words carry the per-field reset level in every level field
  localparam logic [DATA_W-1:0] CFG1_RESET = {5'h00, LEVEL_RESET, 5'h00, LEVEL_RESET,
                                              5'h00, LEVEL_RESET, 5'h00, LEVEL_RESET};
  localparam logic [DATA_W-1:0] CFG2_RESET = {5'h00, LEVEL_RESET, 13'h0000,
                                              LEVEL_RESET, 5'h00, LEVEL_RESET};

  assign cfg1Wr = wrAccess & regSel[SEL_CFG1];
  assign cfg2Wr = wrAccess & regSel[SEL_CFG2];

  always_comb begin
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    if (cfg1Wr) begin
      next_cfg1 = pwdata & MASK_LEVEL_CFG1;
    end
    if (cfg2Wr) begin
      next_cfg2 = pwdata & MASK_LEVEL_CFG2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg1 <= CFG1_RESET;
      cfg2 <= CFG2_RESET;
    end else begin
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
    end
  end

  always_comb begin
    levels.timer2Level       = field_of(cfg1, POS_TIMER2);
    levels.timer1Level       = field_of(cfg1, POS_TIMER1);
    levels.extIn1Level       = field_of(cfg1, POS_EXT_IN1);
    levels.extIn0Level       = field_of(cfg1, POS_EXT_IN0);
    levels.nandCtrlLevel     = field_of(cfg2, POS_NAND);
    levels.extIn3SharedLevel = field_of(cfg2, POS_EXT_IN3S);
    levels.extIn2Level       = field_of(cfg2, POS_EXT_IN2);
  end

  // ---------------- gating and resolution ----------------
  logic [NSRC-1:0] next_srcPending;
  logic [NSRC-1:0] disHitVec;
  // reqPrev resets low like idle request pins, so no false edge follows reset
  logic [NSRC-1:0] reqPrev;
  logic [NSRC-1:0] next_reqPrev;
  ilr_top_s        next_top;

  // ties go to the earlier entry in the order above, i.e. timer 2 first
  always_comb begin
    next_srcPending = '0;
    disHitVec       = '0;
    next_top        = '0;
    next_reqPrev    = reqVec;
    for (int i = 0; i < NSRC; i++) begin
      if (level_enabled(level_at(levels, i))) begin
        next_srcPending[NSRC-1-i] = reqVec[NSRC-1-i];
      end else begin
        disHitVec[NSRC-1-i] = reqVec[NSRC-1-i] & ~reqPrev[NSRC-1-i];
      end
      if (next_srcPending[NSRC-1-i] &&
          (!next_top.valid || level_at(levels, i) > next_top.level)) begin
        next_top.valid  = 1'b1;
        next_top.level  = level_at(levels, i);
        next_top.source = source_at(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srcPending <= '0;
      top        <= '0;
      reqPrev    <= '0;
    end else begin
      srcPending <= next_srcPending;
      top        <= next_top;
      reqPrev    <= next_reqPrev;
    end
  end

  // ---------------- event status, enable, clear ----------------
  logic [EVT_W-1:0] evtStatus;
  logic [EVT_W-1:0] evtEnable;
  logic [EVT_W-1:0] next_evtStatus;
  logic [EVT_W-1:0] next_evtEnable;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;
  logic             next_irq;

  always_comb begin
    evtSet              = '0;
    evtSet[EVT_CFG1_WR] = cfg1Wr;
    evtSet[EVT_CFG2_WR] = cfg2Wr;
    evtSet[EVT_DIS_HIT] = |disHitVec;
    evtSet[EVT_TOP_CHG] = (next_top != top);
    evtClr = '0;
    if (wrAccess && regSel[SEL_CLEAR]) begin
      evtClr = pwdata[EVT_W-1:0];
    end
    // a new event in the clearing cycle survives
    next_evtStatus = (evtStatus & ~evtClr) | evtSet;
    next_evtEnable = evtEnable;
    if (wrAccess && regSel[SEL_ENABLE]) begin
      next_evtEnable = pwdata[EVT_W-1:0];
    end
    // built from next status so irq rises with the status bit, not a cycle later
    next_irq = |(next_evtStatus & next_evtEnable);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evtStatus <= EVT_RESET;
      evtEnable <= EVT_RESET;
      irq       <= 1'b0;
    end else begin
      evtStatus <= next_evtStatus;
      evtEnable <= next_evtEnable;
      irq       <= next_irq;
    end
  end

  // ---------------- read data ----------------
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] next_prdata;

  always_comb begin
    rdMux = '0;
    case (paddr)
      ADDR_LEVEL_CFG1: rdMux = cfg1 & MASK_LEVEL_CFG1;
      ADDR_LEVEL_CFG2: rdMux = cfg2 & MASK_LEVEL_CFG2;
      ADDR_EVT_STATUS: rdMux[EVT_W-1:0] = evtStatus;
      ADDR_EVT_ENABLE: rdMux[EVT_W-1:0] = evtEnable;
      ADDR_RESOLVED: begin
        rdMux[RES_LVL_POS +: LVL_W]  = top.level;
        rdMux[RES_SRC_POS +: SRC_W]  = top.source;
        rdMux[RES_PEND_POS +: NSRC]  = srcPending;
      end
      default: rdMux = '0;
    endcase
    next_prdata = prdata;
    if (setupPhase) begin
      next_prdata = pwrite ? '0 : rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule
`default_nettype wire

// File: ilr_pkg.sv
// Purpose: shared constants and types for the interrupt level assignment registers
// Assumes: APB with 32-bit data, byte addresses
// Notes:   level 0 disables a source, levels 1..7 rank it
package ilr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 3;
  localparam int SRC_W  = 5;
  localparam int NSRC   = 7;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_CFG1 = 16'hF614;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_CFG2 = 16'hF618;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 16'hF630;
  localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 16'hF634;
  localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR  = 16'hF638;
  localparam logic [ADDR_W-1:0] ADDR_RESOLVED   = 16'hF63C;

  // field low bit positions
  localparam int POS_TIMER2   = 24;
  localparam int POS_TIMER1   = 16;
  localparam int POS_EXT_IN1  = 8;
  localparam int POS_EXT_IN0  = 0;
  localparam int POS_NAND     = 24;
  localparam int POS_EXT_IN3S = 8;
  localparam int POS_EXT_IN2  = 0;

  // writable bits; everything else is reserved and reads zero
  localparam logic [DATA_W-1:0] MASK_LEVEL_CFG1 = 32'h07070707;
  localparam logic [DATA_W-1:0] MASK_LEVEL_CFG2 = 32'h07000707;

  localparam logic [LVL_W-1:0] LEVEL_RESET    = 3'h0;
  localparam logic [LVL_W-1:0] LEVEL_DISABLED = 3'h0;

  // controller source numbers
  localparam logic [SRC_W-1:0] SRC_TIMER2   = 5'h13;
  localparam logic [SRC_W-1:0] SRC_TIMER1   = 5'h12;
  localparam logic [SRC_W-1:0] SRC_EXT_IN1  = 5'h03;
  localparam logic [SRC_W-1:0] SRC_EXT_IN0  = 5'h02;
  localparam logic [SRC_W-1:0] SRC_NAND     = 5'h15;
  localparam logic [SRC_W-1:0] SRC_EXT_IN3S = 5'h05;
  localparam logic [SRC_W-1:0] SRC_EXT_IN2  = 5'h04;

  // event status bits
  localparam int EVT_W        = 4;
  localparam int EVT_CFG1_WR  = 0;
  localparam int EVT_CFG2_WR  = 1;
  localparam int EVT_DIS_HIT  = 2;
  localparam int EVT_TOP_CHG  = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // resolved word layout
  localparam int RES_LVL_POS  = 0;
  localparam int RES_SRC_POS  = 8;
  localparam int RES_PEND_POS = 16;

  typedef struct packed {
    logic [LVL_W-1:0] timer2Level;
    logic [LVL_W-1:0] timer1Level;
    logic [LVL_W-1:0] extIn1Level;
    logic [LVL_W-1:0] extIn0Level;
    logic [LVL_W-1:0] nandCtrlLevel;
    logic [LVL_W-1:0] extIn3SharedLevel;
    logic [LVL_W-1:0] extIn2Level;
  } ilr_levels_s;

  typedef struct packed {
    logic             valid;
    logic [LVL_W-1:0] level;
    logic [SRC_W-1:0] source;
  } ilr_top_s;

endpackage

// File: ilr_src_model.sv
// Purpose: stand-in for the peripheral request sources
// Assumes: bench updates the wanted vector just after a rising edge
// Notes:   requests leave a flop, like a real peripheral's
`timescale 1ns/100ps
`default_nettype none
module ilr_src_model (
  input  wire logic       clk,          // system clock
  input  wire logic [7:0] want,         // {eth,ext3..ext0,nand,t1,t2}
  output logic            timer2Req,    // timer 2 request
  output logic            timer1Req,    // timer 1 request
  output logic            nandCtrlReq,  // nand request
  output logic [3:0]      extInPin,     // external pins
  output logic            ethCh1Req     // ethernet 1 request
);
  always_ff @(posedge clk) begin
    {ethCh1Req, extInPin, nandCtrlReq, timer1Req, timer2Req} <= want;
  end
endmodule
`default_nettype wire

// File: ilr_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous input pins
// Assumes: synchronous active-high reset
// Notes:   only the second stage may be read downstream
`timescale 1ns/100ps
`default_nettype none
module ilr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // system clock
  input  wire logic             rst,    // sync reset, active high
  input  wire logic [WIDTH-1:0] async,  // raw pin levels
  output logic      [WIDTH-1:0] synced  // retimed levels
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_synced;

  always_comb begin
    next_stage1 = async;
    next_synced = stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end

endmodule
`default_nettype wire

// File: tb_irq_level_assign_regs_1_2.sv
// Purpose: self-checking bench for the level assignment registers
// Assumes: zero-wait apb slave, requests from the source model
// Notes:   one idle cycle between transfers keeps each driver assignment single
`timescale 1ns/100ps
`default_nettype none
module tb_irq_level_assign_regs_1_2;
  import ilr_pkg::*;
  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [7:0]        want;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              timer2Req;
  logic              timer1Req;
  logic              nandCtrlReq;
  logic [3:0]        extInPin;
  logic              ethCh1Req;
  ilr_levels_s       levels;
  logic [NSRC-1:0]   srcPending;
  ilr_top_s          top;
  logic              irq;
  int                nMismatch;
  int                totalChecks;
  int                cyc;
  ilr_src_model SRC (.clk(clk), .want(want), .timer2Req(timer2Req), .timer1Req(timer1Req),
    .nandCtrlReq(nandCtrlReq), .extInPin(extInPin), .ethCh1Req(ethCh1Req));
  ilr_level_regs DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer2Req(timer2Req), .timer1Req(timer1Req), .nandCtrlReq(nandCtrlReq),
    .extInPin(extInPin), .ethCh1Req(ethCh1Req), .levels(levels), .srcPending(srcPending),
    .top(top), .irq(irq));
  always #2.5 clk = ~clk;
  task automatic wrapUp();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      nMismatch++;
      wrapUp();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // entered and left just after a rising edge; the wait is cut short only by the timeout
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_fields();
    logic [31:0] r;
    logic        e;
    apb(1'b0, ADDR_LEVEL_CFG1, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(levels), 32'h0);
    apb(1'b1, ADDR_LEVEL_CFG1, 32'h5B3CA2F1, r, e);
    apb(1'b1, ADDR_LEVEL_CFG2, 32'hCEFFFF3D, r, e);
    apb(1'b0, ADDR_LEVEL_CFG1, 32'h0, r, e);
    chk(r, 32'h03040201);
    apb(1'b0, ADDR_LEVEL_CFG2, 32'h0, r, e);
    chk(r, 32'h06000705);
    chk(32'(levels), 32'({3'h3, 3'h4, 3'h2, 3'h1, 3'h6, 3'h7, 3'h5}));
    apb(1'b0, 16'hF600, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask
  task automatic t_levels();
    logic [31:0] r;
    logic        e;
    logic [2:0]  lv;
    for (int i = 0; i < 8; i++) begin
      lv = i[2:0];
      apb(1'b1, ADDR_LEVEL_CFG1, {5'h0, lv, 24'h0}, r, e);
      want <= 8'h01;
      repeat (4) @(posedge clk);
      chk(32'({srcPending[6], top.valid}), lv != 3'h0 ? 32'h3 : 32'h0);
      if (lv != 3'h0) chk(32'({top.level, top.source}), 32'({lv, SRC_TIMER2}));
      want <= 8'h00;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic t_shared();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_LEVEL_CFG2, 32'h00000400, r, e);
    for (int k = 6; k < 8; k++) begin
      want <= 8'(1 << k);
      repeat (6) @(posedge clk);
      chk(32'({srcPending, top}), 32'({7'h02, 1'b1, 3'h4, SRC_EXT_IN3S}));
      apb(1'b0, ADDR_RESOLVED, 32'h0, r, e);
      chk(r, 32'h00020504);
      want <= 8'h00;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic t_irq();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_EVT_CLEAR, 32'hF, r, e);
    apb(1'b1, ADDR_EVT_ENABLE, 32'h0, r, e);
    apb(1'b1, ADDR_LEVEL_CFG1, 32'h0, r, e);
    chk(32'(irq), 32'h0);
    apb(1'b0, ADDR_EVT_STATUS, 32'h0, r, e);
    chk(r, 32'h1);
    want <= 8'h01;
    repeat (4) @(posedge clk);
    want <= 8'h00;
    apb(1'b0, ADDR_EVT_STATUS, 32'h0, r, e);
    chk(r, 32'h5);
    apb(1'b1, ADDR_EVT_ENABLE, 32'h1, r, e);
    chk(32'(irq), 32'h1);
    apb(1'b1, ADDR_EVT_CLEAR, 32'h1, r, e);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_LEVEL_CFG1, 32'h07070707, r, e);
    apb(1'b1, ADDR_LEVEL_CFG2, 32'h07000707, r, e);
    chk(32'(levels), 32'h1FFFFF);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({irq, levels}), 32'h0);
    apb(1'b0, ADDR_LEVEL_CFG1, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, ADDR_LEVEL_CFG2, 32'h0, r, e);
    chk(r, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    want = 8'h00;
    nMismatch = 0;
    totalChecks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_fields();
    t_levels();
    t_shared();
    t_irq();
    t_reset();
    wrapUp();
  end
endmodule
bind ilr_level_regs ilr_checker CHK (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .timer2Req(timer2Req),
  .levels(levels), .srcPending(srcPending), .top(top));
`default_nettype wire
